// *** design/exmon_cfg.svh ***
// Constants of the exclusive access monitor: tag low bit, granule limits, status codes.
// Assumes a 32-bit byte address and a single clock.
`ifndef EXMON_CFG_SVH
`define EXMON_CFG_SVH
`define EXMON_ADDR_W      32
`define EXMON_TAG_LSB     4
`define EXMON_TAG_LSB_MIN 2
`define EXMON_TAG_LSB_MAX 11
`define EXMON_GRANULE_MAX 2048
`define EXMON_NUM_CPU     2
`define EXMON_CPU_IDX_W   1
`define EXMON_STATUS_OK   1'h0
`define EXMON_STATUS_FAIL 1'h1
`endif

// *** design/exmon_pkg.sv ***
// Types shared by the exclusive access monitor modules.
// Assumes exmon_cfg.svh is on the include path.
package exmon_pkg;
  typedef enum logic [1:0] {
    EXMON_OPEN = 2'h1,
    EXMON_EXCL = 2'h2
  } exmon_state_t;

  typedef enum logic [2:0] {
    EXMON_SIZE_BYTE = 3'h1,
    EXMON_SIZE_HALF = 3'h2,
    EXMON_SIZE_WORD = 3'h4
  } exmon_size_t;
endpackage

// *** design/exmon_global_fsm.sv ***
// One per-processor state machine of the global monitor.
// Assumes the top feeds it decoded access strobes of one cycle each.
`timescale 1ns/1ps
`include "exmon_cfg.svh"
module exmon_global_fsm (
  // Clock and reset
  input  wire logic                                          sys_clk,
  input  wire logic                                          nrst,
  // Own processor's exclusive accesses
  input  wire logic                                          ownLoadExcl,
  input  wire logic                                          ownStoreExcl,
  // Any shareable store that updates memory (own or other observer)
  input  wire logic                                          anyStoreWrite,
  input  wire logic [`EXMON_ADDR_W-1:`EXMON_TAG_LSB]         accessTag,
  // State
  output logic                                               isExclusive,
  output logic [`EXMON_ADDR_W-1:`EXMON_TAG_LSB]              tagOut
);
  exmon_pkg::exmon_state_t                      state_q, state_d;
  logic [`EXMON_ADDR_W-1:`EXMON_TAG_LSB]        tag_q, tag_d;

  always_comb begin
    state_d = state_q;
    tag_d   = tag_q;
    case (state_q)
      exmon_pkg::EXMON_OPEN: begin
        if (ownLoadExcl) begin
          state_d = exmon_pkg::EXMON_EXCL;
          tag_d   = accessTag;
        end
      end
      exmon_pkg::EXMON_EXCL: begin
        if (ownLoadExcl) begin
          tag_d = accessTag;
        end else if (anyStoreWrite && accessTag == tag_q) begin
          // A write into the granule, including a successful own store, opens it
          state_d = exmon_pkg::EXMON_OPEN;
        end else if (ownStoreExcl) begin
          state_d = exmon_pkg::EXMON_OPEN;
        end
      end
      default: state_d = exmon_pkg::EXMON_OPEN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= exmon_pkg::EXMON_OPEN;
      tag_q   <= '0;
    end else begin
      state_q <= state_d;
      tag_q   <= tag_d;
    end
  end

  assign isExclusive = (state_q == exmon_pkg::EXMON_EXCL);
  assign tagOut      = tag_q;
endmodule

// *** design/exmon_monitor.sv ***
// Exclusive access monitor: local monitor for one core plus global per-processor monitors.
// Answers exclusive loads, exclusive stores and plain stores with a status and a memory write enable.
// Assumes one access request per cycle, synchronous to sys_clk, answered in the next cycle.
// Assumes processor 0 is the local core; other processors reach only the global monitors.
`timescale 1ns/1ps
`include "exmon_cfg.svh"
module exmon_monitor (
  // Clock and reset
  input  wire logic                                 sys_clk,
  input  wire logic                                 nrst,
  // Access request from a core
  input  wire logic                                 reqValid,
  input  wire logic [`EXMON_CPU_IDX_W-1:0]          reqCpu,
  input  wire logic                                 reqLoadExcl,
  input  wire logic                                 reqStoreExcl,
  input  wire logic                                 reqStore,
  input  wire logic                                 reqClearExcl,
  input  wire logic                                 reqShareable,
  input  wire exmon_pkg::exmon_size_t               reqSize,
  input  wire logic [`EXMON_ADDR_W-1:0]             reqAddr,
  // Context and implementation events of the local core
  input  wire logic                                 excEntry,
  input  wire logic                                 excReturn,
  input  wire logic                                 evictClear,
  // Answer
  output logic                                      rspValid,
  output logic                                      rspStatus,
  output logic                                      rspWriteMem,
  output logic                                      localExclusive,
  output logic [`EXMON_NUM_CPU-1:0]                 globalExclusive
);
  localparam int TagLsb = `EXMON_TAG_LSB;
  localparam bit GranuleOk = (TagLsb >= `EXMON_TAG_LSB_MIN) && (TagLsb <= `EXMON_TAG_LSB_MAX) &&
                             ((1 << TagLsb) <= `EXMON_GRANULE_MAX);

  // Bits of a byte address that name its reservation granule
  function automatic logic [`EXMON_ADDR_W-1:`EXMON_TAG_LSB] tagOf(input logic [`EXMON_ADDR_W-1:0] a);
    tagOf = a[`EXMON_ADDR_W-1:`EXMON_TAG_LSB];
  endfunction

  // True when a request index names processor idx
  function automatic logic cpuIs(input logic [`EXMON_CPU_IDX_W-1:0] cpu, input int idx);
    cpuIs = (cpu == idx[`EXMON_CPU_IDX_W-1:0]);
  endfunction

  // a granule outside its legal range stops elaboration
  if (!GranuleOk) begin : gBadGranule
    $error("reservation granule size out of range");
  end

  // Decoded request
  logic                                  isLocal;
  logic                                  localReq;
  logic                                  localKill;
  logic                                  reqLdx;
  logic                                  reqStx;
  logic                                  reqSt;
  logic                                  sharedReq;
  logic [`EXMON_ADDR_W-1:`EXMON_TAG_LSB] reqTag;

  // Local monitor
  exmon_pkg::exmon_state_t               locState_q, locState_d;
  exmon_pkg::exmon_size_t                locSize_q, locSize_d;
  logic                                  localOk;

  // Global monitors
  logic [`EXMON_NUM_CPU-1:0]             glbExcl;
  logic [`EXMON_ADDR_W-1:`EXMON_TAG_LSB] glbTag [`EXMON_NUM_CPU];
  logic [`EXMON_NUM_CPU-1:0]             glbHit;
  logic [`EXMON_NUM_CPU-1:0]             ownShared;
  logic                                  globalOk;
  logic                                  storeOk;
  logic                                  sharedWrite;

  // Answer
  logic                                  rspValid_d, rspValid_q;
  logic                                  rspStatus_d, rspStatus_q;
  logic                                  rspWrite_d, rspWrite_q;

  // Request strobes, one kind at a time
  assign isLocal   = cpuIs(reqCpu, 0);
  assign localReq  = reqValid && isLocal;
  assign localKill = excEntry || excReturn || evictClear;
  assign reqLdx    = reqValid && reqLoadExcl;
  assign reqStx    = reqValid && reqStoreExcl;
  assign reqSt     = reqValid && reqStore;
  assign sharedReq = reqValid && reqShareable;
  assign reqTag    = tagOf(reqAddr);

  // Per processor: does the request belong to it, and does it hit its tag
  for (genvar i = 0; i < `EXMON_NUM_CPU; i++) begin : gHit
    assign ownShared[i] = sharedReq && cpuIs(reqCpu, i);
    assign glbHit[i]    = glbExcl[i] && (glbTag[i] == reqTag);
  end

  // local check looks at state and size only, not address
  assign localOk     = (locState_q == exmon_pkg::EXMON_EXCL) && (locSize_q == reqSize);
  // Non-shareable stores bypass the global monitors
  assign globalOk    = !reqShareable || glbHit[reqCpu];
  assign storeOk     = reqStx && (!isLocal || localOk) && globalOk;
  // A successful store-exclusive writes memory like a plain store
  assign sharedWrite = sharedReq && (reqStore || storeOk);

  // Local monitor: exception and eviction events beat a same-cycle load-exclusive
  always_comb begin
    locState_d = locState_q;
    locSize_d  = locSize_q;
    case (locState_q)
      exmon_pkg::EXMON_OPEN: begin
        if (!localKill && localReq && reqLoadExcl) begin
          locState_d = exmon_pkg::EXMON_EXCL;
          locSize_d  = reqSize;
        end else if (localReq && reqStoreExcl) begin
          locState_d = exmon_pkg::EXMON_OPEN;
        end
      end
      exmon_pkg::EXMON_EXCL: begin
        if (excEntry || excReturn) begin
          locState_d = exmon_pkg::EXMON_OPEN;
        end else if (evictClear) begin
          locState_d = exmon_pkg::EXMON_OPEN;
        end else if (localReq && reqClearExcl) begin
          locState_d = exmon_pkg::EXMON_OPEN;
        end else if (localReq && reqLoadExcl) begin
          locSize_d  = reqSize;
        end else if (localReq && reqStoreExcl) begin
          locState_d = exmon_pkg::EXMON_OPEN;
        end
      end
      default: begin
        locState_d = exmon_pkg::EXMON_OPEN;
      end
    endcase
  end

  // Local monitor registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      locState_q <= exmon_pkg::EXMON_OPEN;
      locSize_q  <= exmon_pkg::EXMON_SIZE_WORD;
    end else begin
      locState_q <= locState_d;
      locSize_q  <= locSize_d;
    end
  end

  // Answer for exclusive loads, exclusive stores and plain stores
  always_comb begin
    rspValid_d  = 1'h0;
    rspStatus_d = `EXMON_STATUS_OK;
    rspWrite_d  = 1'h0;
    if (reqLdx) begin
      rspValid_d = 1'h1;
    end else if (reqStx) begin
      rspValid_d  = 1'h1;
      rspStatus_d = storeOk ? `EXMON_STATUS_OK : `EXMON_STATUS_FAIL;
      rspWrite_d  = storeOk;
    end else if (reqSt) begin
      rspValid_d = 1'h1;
      rspWrite_d = 1'h1;
    end
  end

  // Answer registers: each answer stands for one cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rspValid_q  <= 1'h0;
      rspStatus_q <= `EXMON_STATUS_OK;
      rspWrite_q  <= 1'h0;
    end else begin
      rspValid_q  <= rspValid_d;
      rspStatus_q <= rspStatus_d;
      rspWrite_q  <= rspWrite_d;
    end
  end

  // Global monitors, one per processor, watching all shareable traffic
  // Clear-exclusive leaves them alone; only loads, stores and exclusive stores move them
  for (genvar i = 0; i < `EXMON_NUM_CPU; i++) begin : gGlobal
    exmon_global_fsm uFsm (
      .sys_clk       (sys_clk),
      .nrst          (nrst),
      .ownLoadExcl   (ownShared[i] && reqLoadExcl),
      .ownStoreExcl  (ownShared[i] && reqStoreExcl),
      .anyStoreWrite (sharedWrite),
      .accessTag     (reqTag),
      .isExclusive   (glbExcl[i]),
      .tagOut        (glbTag[i])
    );
  end

  // Outputs straight from registers
  assign rspValid        = rspValid_q;
  assign rspStatus       = rspStatus_q;
  assign rspWriteMem     = rspWrite_q;
  assign localExclusive  = (locState_q == exmon_pkg::EXMON_EXCL);
  assign globalExclusive = glbExcl;
endmodule

// *** sim/exmon_monitor_props.sv ***
// Assertions on the exclusive access monitor ports.
// Assumes it is bound to exmon_monitor.
`timescale 1ns/1ps
`include "exmon_cfg.svh"
module exmon_monitor_props (
  // Watched ports
  input wire logic                       sys_clk,
  input wire logic                       nrst,
  input wire logic                       reqValid,
  input wire logic [`EXMON_CPU_IDX_W-1:0] reqCpu,
  input wire logic                       reqLoadExcl,
  input wire logic                       reqStoreExcl,
  input wire logic                       reqClearExcl,
  input wire logic                       excEntry,
  input wire logic                       excReturn,
  input wire logic                       evictClear,
  input wire logic                       rspValid,
  input wire logic                       rspStatus,
  input wire logic                       rspWriteMem,
  input wire logic                       localExclusive,
  input wire logic [`EXMON_NUM_CPU-1:0]   globalExclusive
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire logic own = reqValid && reqCpu == '0;
  wire logic kill = excEntry || excReturn || evictClear;
  property p_rsp; reqValid && !reqClearExcl |=> rspValid; endproperty
  a_rsp: assert property (p_rsp) else $error("no answer");
  property p_ldx; own && reqLoadExcl && !kill |=> localExclusive; endproperty
  a_ldx: assert property (p_ldx) else $error("load not tagged");
  property p_clr; own && reqClearExcl |=> !localExclusive; endproperty
  a_clr: assert property (p_clr) else $error("clear kept tag");
  property p_exc; excEntry || excReturn |=> !localExclusive; endproperty
  a_exc: assert property (p_exc) else $error("exception kept tag");
  property p_evc; evictClear |=> !localExclusive; endproperty
  a_evc: assert property (p_evc) else $error("evict kept tag");
  property p_open; own && reqStoreExcl && !localExclusive |=> rspStatus && !rspWriteMem; endproperty
  a_open: assert property (p_open) else $error("open store passed");
  property p_sx; own && reqStoreExcl |=> !localExclusive; endproperty
  a_sx: assert property (p_sx) else $error("store kept tag");
  property p_stat; rspValid && rspStatus |-> !rspWriteMem; endproperty
  a_stat: assert property (p_stat) else $error("failed store wrote");
  property p_rst; $rose(nrst) |-> !localExclusive && globalExclusive == '0; endproperty
  a_rst: assert property (p_rst) else $error("not open after reset");
endmodule
bind exmon_monitor exmon_monitor_props u_props (.*);

// *** sim/exmon_core_model.sv ***
// Model of the cores issuing exclusive and plain accesses.
// Assumes the bench calls op; drives at falling edges.
`timescale 1ns/1ps
`include "exmon_cfg.svh"
module exmon_core_model (
  // Clock
  input wire logic                        sys_clk,
  // Request
  output logic                            reqValid,
  output logic [`EXMON_CPU_IDX_W-1:0]     reqCpu,
  output logic                            reqLoadExcl,
  output logic                            reqStoreExcl,
  output logic                            reqStore,
  output logic                            reqClearExcl,
  output logic                            reqShareable,
  output exmon_pkg::exmon_size_t          reqSize,
  output logic [`EXMON_ADDR_W-1:0]        reqAddr
);
  initial begin
    {reqValid, reqCpu, reqLoadExcl, reqStoreExcl, reqStore, reqClearExcl, reqAddr} = '0;
    reqShareable = 1'h1;
    reqSize = exmon_pkg::EXMON_SIZE_WORD;
  end
  // Kind 0 load-excl, 1 store-excl, 2 store, 3 clear; caller keeps pairs on one granule
  task automatic op(input logic [`EXMON_CPU_IDX_W-1:0] cpu, input int k, input logic [31:0] a,
                    input exmon_pkg::exmon_size_t sz = exmon_pkg::EXMON_SIZE_WORD, input logic sh = 1'h1);
    @(negedge sys_clk);
    {reqLoadExcl, reqStoreExcl, reqStore, reqClearExcl} = 4'h8 >> k;
    reqValid = 1'h1;
    reqSize = sz;
    reqShareable = sh;
    reqCpu = cpu;
    reqAddr = a;
    // Each access completes before the next one is issued
    @(negedge sys_clk);
    {reqValid, reqLoadExcl, reqStoreExcl, reqStore, reqClearExcl} = '0;
    reqAddr = ~reqAddr;
  endtask
endmodule

// *** sim/exmon_monitor_tb_top.sv ***
// Self-checking bench of the exclusive access monitor.
// Assumes design and checker files are compiled first.
`timescale 1ns/1ps
`include "exmon_cfg.svh"
module exmon_monitor_tb_top;
  logic sys_clk, nrst, excEntry, excReturn, evictClear;
  wire logic reqValid, reqLoadExcl, reqStoreExcl, reqStore, reqClearExcl, reqShareable;
  wire logic [`EXMON_CPU_IDX_W-1:0] reqCpu;
  wire exmon_pkg::exmon_size_t reqSize;
  wire logic [`EXMON_ADDR_W-1:0] reqAddr;
  logic rspValid, rspStatus, rspWriteMem, localExclusive;
  logic [`EXMON_NUM_CPU-1:0] globalExclusive;
  int n_fail, checked;
  exmon_core_model core (.*);
  exmon_monitor dut (.*);
  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [2:0] seen, input logic [2:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Answer, status and memory write of a store-exclusive
  function automatic logic [2:0] stx(input bit ok);
    return ok ? 3'h5 : 3'h6;
  endfunction
  task automatic sx(input int cpu, input logic [31:0] a, input bit ok);
    core.op(cpu[0], 1, a);
    chk("store excl", {rspValid, rspStatus, rspWriteMem}, stx(ok));
  endtask
  task automatic pulse(input int w);
    @(negedge sys_clk);
    {excEntry, excReturn, evictClear} = 3'h4 >> w;
    @(negedge sys_clk);
    {excEntry, excReturn, evictClear} = '0;
  endtask
  task automatic do_reset;
    nrst = 1'h0;
    repeat (5) @(negedge sys_clk);
    nrst = 1'h1;
    chk("reset", {localExclusive, |globalExclusive}, 2'h0);
  endtask
  initial begin
    logic [31:0] a;
    {nrst, excEntry, excReturn, evictClear} = '0;
    void'($urandom(4433));
    do_reset();
    sx(0, 32'h100, 0);
    for (int i = 0; i < 40; i++) begin
      a = $urandom;
      core.op(0, 0, a);
      chk("load excl", {localExclusive, globalExclusive[0]}, 2'h3);
      chk("load answer", {rspValid, rspStatus, rspWriteMem}, 3'h4);
      if (i % 5 == 1) begin
        core.op(0, 3, a);
        chk("clear answer", {rspValid, rspStatus, rspWriteMem}, 3'h0);
        chk("clear state", {localExclusive, globalExclusive[0]}, 2'h1);
      end
      if (i % 5 > 1) pulse(i % 5 - 2);
      sx(0, {a[31:4], 2'($urandom), 2'h0}, i % 5 == 0);
      if (i % 5 == 0) sx(0, a, 0);
    end
    core.op(0, 0, 32'h2000);
    core.op(1, 2, 32'h2008);
    chk("store answer", {rspValid, rspStatus, rspWriteMem}, 3'h5);
    chk("other store in", {localExclusive, globalExclusive[0]}, 2'h2);
    sx(0, 32'h2000, 0);
    core.op(0, 0, 32'h3000);
    core.op(1, 2, 32'h3010);
    chk("other store out", {localExclusive, globalExclusive[0]}, 2'h3);
    sx(0, 32'h3004, 1);
    core.op(1, 0, 32'h4000);
    chk("other load", {1'h0, globalExclusive[1]}, 2'h1);
    sx(1, 32'h4000, 1);
    core.op(0, 0, 32'h6000, exmon_pkg::EXMON_SIZE_BYTE);
    sx(0, 32'h6000, 0);
    core.op(0, 0, 32'h7000);
    core.op(1, 2, 32'h7004, exmon_pkg::EXMON_SIZE_WORD, 1'h0);
    chk("private store", {localExclusive, globalExclusive[0]}, 2'h3);
    sx(0, 32'h7000, 1);
    core.op(0, 0, 32'h5000);
    do_reset();
    complete_run();
  end
  initial begin
    #50000;
    n_fail++;
    complete_run();
  end
endmodule
